// *** src/cbsc_pkg.sv ***
// Shared constants for the bus special-cycle and ownership block.
package cbsc_pkg;
   // Register offsets on the plain register port.
   localparam logic [7:0]  REG_CONFIG       = 8'h00;
   localparam logic [7:0]  REG_STATUS       = 8'h04;
   localparam logic [7:0]  REG_VECTOR       = 8'h08;
   // Field positions in the core configuration register.
   localparam int          CFG_KEN_EN       = 0;
   localparam int          CFG_INVALIDATE_ON_GRANT_BIT         = 1;
   localparam int          CFG_FLUSH_EN     = 2;
   localparam int          CFG_A20_EN       = 3;
   localparam int          CFG_NC0          = 4;
   localparam logic [4:0]  CFG_RST          = 5'h00;
   // Field positions in the status register.
   localparam int          STS_HALTED       = 0;
   localparam int          STS_SHUTDOWN     = 1;
   localparam int          STS_GRANT        = 2;
   localparam int          STS_LOCK         = 3;
   localparam int          STS_NMI_PEND     = 4;
   localparam int          STS_A20_MASKED   = 5;
   // Word addresses (A23..A1) of the special cycles.
   localparam logic [23:1] INTA1_ADDR       = 23'h000002;
   localparam logic [23:1] INTA2_ADDR       = 23'h000000;
   localparam logic [23:1] HALT_ADDR        = 23'h000001;
   localparam logic [23:1] SHUT_ADDR        = 23'h000000;
   // Last count of the four idle bus states between the two acknowledge cycles.
   localparam logic [1:0]  IRQ_ACK_CYCLE_GAP_LAST    = 2'h3;
   // Reset values of the synchronised pins (ready, hold, irq, nmi,
   // cacheable, flush, mask, data).
   localparam int          SYNC_W           = 23;
   localparam logic [22:0] SYNC_RST         = 23'h470000;
   // Bus state machine.
   typedef enum logic [2:0] {
      S_IDLE = 3'b000,
      S_T1   = 3'b001,
      S_T2   = 3'b010,
      S_HOLD = 3'b011,
      S_GAP  = 3'b100
   } cbsc_state_t;
   // Kind of the cycle being run.
   typedef enum logic [2:0] {
      K_CORE  = 3'b000,
      K_INTA1 = 3'b001,
      K_INTA2 = 3'b010,
      K_HALT  = 3'b011,
      K_SHUT  = 3'b100
   } cbsc_kind_t;
endpackage

// *** src/cbsc_sync.sv ***
// Two-flop synchroniser for a group of pin inputs.
module cbsc_sync #(
   parameter int              W       = 1,
   parameter logic [W-1:0]    RST_VAL = '0
) (
   input  wire logic          clk_i,
   input  wire logic          rst_n_i,
   input  wire logic [W-1:0]  d_i,
   output      logic [W-1:0]  q_o
);
   logic [W-1:0] meta_ff;

   // The first stage is read only by the second stage.
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_ff <= RST_VAL;
         q_o     <= RST_VAL;
      end else begin
         meta_ff <= d_i;
         q_o     <= meta_ff;
      end
   end
endmodule

// *** src/cbsc_bus_special.sv ***
// Special bus cycles, cache qualification, bit 20 masking and hold.
// Functional notes
// RQ1 - Lock blocks bus surrender; set for locked RMW and acknowledges.
// RQ2 - Lock rises on edge starting first locked cycle, drops at last ready.
// RQ3 - Enabled maskable request runs two locked read-like acknowledge cycles.
// RQ4 - First acknowledge drives address 4h, second 0h, upper enable high.
// RQ5 - Exactly four idle states between acknowledges; lock held throughout.
// RQ6 - Vector byte taken from low data lines at second acknowledge end.
// RQ7 - Data lines float in acknowledges; first acknowledge data discarded.
// RQ8 - Halt runs an indication cycle at address 2h, unlocked, then stops.
// RQ9 - Halt cycle ends on ready; resume on enabled irq, nmi or reset.
// RQ10 - Fatal error runs shutdown cycle at 0h, ended by ready.
// RQ11 - Shutdown resumes only on nmi or reset, never on maskable request.
// RQ12 - Cache unlocked reads outside no-cache regions; input needs enable.
// RQ13 - Cacheable input sampled one clock before ready; fill one word.
// RQ14 - Invalidate on instructions, on grant with bit, on flush with bit.
// RQ15 - Flush sampled at phase 2 start, needs two clocks held.
// RQ16 - Bit 20 masked only with config bit, input asserted, paging off.
// RQ17 - Mask input sampled at phase 2, applied from next access.
// RQ18 - Low-region bit stops caching first 64K and 64K at 1M.
// RQ19 - Surrender floats bus, keeps grant, ignores most inputs.
// RQ20 - Hold sampled at phase 1 start; enter from idle, never while locked.
// RQ21 - Hold drop leaves to idle or first state; hold after reset honoured.
// RQ22 - Nmi rising edge in surrender latched, serviced after leaving.
// RQ23 - Double-rate clock divided by two into phase 1 and phase 2.
//
// Strobed register access and the register offsets were decided locally.
module cbsc_bus_special (
   input  wire logic        CLOCK_I,
   input  wire logic        RSTN_I,
   input  wire logic [7:0]  REG_ADDR_I,
   input  wire logic [31:0] REG_WDATA_I,
   input  wire logic        REG_WR_I,
   input  wire logic        REG_RD_I,
   output      logic [31:0] REG_RDATA_O,
   input  wire logic        CORE_REQ_I,
   input  wire logic [23:1] CORE_ADDR_I,
   input  wire logic        CORE_WR_I,
   input  wire logic        CORE_MIO_I,
   input  wire logic        CORE_DC_I,
   input  wire logic        CORE_BHE_N_I,
   input  wire logic        CORE_BLE_N_I,
   input  wire logic [15:0] CORE_WDATA_I,
   input  wire logic        CORE_LOCK_I,
   input  wire logic        CORE_LOCK_LAST_I,
   input  wire logic        CORE_NONCACHE_I,
   input  wire logic        CORE_IF_I,
   input  wire logic        CORE_PAGING_I,
   input  wire logic        CORE_HALT_I,
   input  wire logic        CORE_SHUTDOWN_I,
   input  wire logic        CORE_INVALIDATE_INSN_I,
   input  wire logic        CORE_WRITEBACK_INVALIDATE_INSN_I,
   input  wire logic        CORE_NMI_ACK_I,
   output      logic        CORE_DONE_O,
   output      logic [15:0] CORE_RDATA_O,
   output      logic        NMI_PEND_O,
   output      logic        HALTED_O,
   output      logic [7:0]  IRQ_VECTOR_O,
   output      logic        IRQ_VEC_VALID_O,
   output      logic        CACHE_FILL_O,
   output      logic [15:0] CACHE_FILL_DATA_O,
   output      logic        CACHE_INV_O,
   output      logic        A20_MASKED_O,
   input  wire logic        READY_N_I,
   input  wire logic        HOLD_I,
   input  wire logic        MASKABLE_IRQ_REQ_I,
   input  wire logic        NMI_I,
   input  wire logic        CACHEABLE_CYCLE_N_I,
   input  wire logic        FLUSH_N_I,
   input  wire logic        ADDR_BIT20_MASK_N_I,
   input  wire logic [15:0] DATA_I,
   output      logic        ADS_N_O,
   output      logic [23:1] ADDR_O,
   output      logic        UPPER_BYTE_ENABLE_N_O,
   output      logic        LOWER_BYTE_ENABLE_N_O,
   output      logic        MIO_O,
   output      logic        DC_O,
   output      logic        WR_O,
   output      logic        LOCK_N_O,
   output      logic        BUS_OE_O,
   output      logic [15:0] DATA_O,
   output      logic        DATA_OE_O,
   output      logic        BUS_GRANT_ACK_O
);
   logic                 rst_meta_ff;
   logic                 rst_n;
   logic [22:0]          pin_s;
   logic                 ready_s, hold_s, irq_s, nmi_s;
   logic                 ken_s, flush_s, addr_bit20_mask_n_s;
   logic [15:0]          data_s;
   logic                 phase_ff;
   logic                 st_end;
   cbsc_pkg::cbsc_state_t state_ff, nxt_state;
   cbsc_pkg::cbsc_kind_t  kind_ff, nxt_kind, pick_kind;
   logic                 pick_ok;
   logic                 start;
   logic                 cyc_end;
   logic [1:0]           gap_cnt_ff;
   logic                 lock_ff, lock_last_ff, cyc_rd_mem_ff;
   logic                 ken_smp_ff;
   logic                 halt_pend_ff, shut_pend_ff;
   logic                 halted_ff, shut_ff;
   logic                 nmi_prev_ff, nmi_pend_ff;
   logic                 flush_prev_ff;
   logic                 a20_req_ff, a20_cur_ff;
   logic [4:0]           cfg_ff;
   logic [7:0]           vector_ff;
   logic                 irq_go, core_go, low_region, cacheable;

   // Reset is asserted at once and released through two flops.
   always_ff @(posedge CLOCK_I or negedge RSTN_I) begin
      if (!RSTN_I) begin
         rst_meta_ff <= 1'b0;
         rst_n       <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n       <= rst_meta_ff;
      end
   end

   // All system pins are synchronised before any logic reads them.
   cbsc_sync #(.W(cbsc_pkg::SYNC_W), .RST_VAL(cbsc_pkg::SYNC_RST)) u_sync (
      .clk_i   (CLOCK_I),
      .rst_n_i (rst_n),
      .d_i     ({READY_N_I, HOLD_I, MASKABLE_IRQ_REQ_I, NMI_I,
                 CACHEABLE_CYCLE_N_I, FLUSH_N_I, ADDR_BIT20_MASK_N_I,
                 DATA_I}),
      .q_o     (pin_s)
   );
   assign ready_s = !pin_s[22];
   assign hold_s  = pin_s[21];
   assign irq_s   = pin_s[20];
   assign nmi_s   = pin_s[19];
   assign ken_s   = !pin_s[18];
   assign flush_s = !pin_s[17];
   assign addr_bit20_mask_n_s  = !pin_s[16];
   assign data_s  = pin_s[15:0];

   // Phase 1 is phase_ff low; a bus state ends on the phase 2 edge.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) phase_ff <= 1'b0;
      else        phase_ff <= !phase_ff; // [RQ23]
   end
   assign st_end  = phase_ff;
   assign cyc_end = (state_ff == cbsc_pkg::S_T2) && st_end && ready_s;

   // Shutdown blocks acknowledges; halt still accepts an enabled irq.
   assign irq_go  = irq_s && CORE_IF_I && !shut_ff && !lock_ff; // [RQ3] [RQ11]
   assign core_go = CORE_REQ_I && !halted_ff && !shut_ff;

   // Priority of the next cycle: shutdown, halt, acknowledge, core.
   always_comb begin
      pick_ok   = 1'b1;
      pick_kind = cbsc_pkg::K_CORE;
      if (shut_pend_ff)      pick_kind = cbsc_pkg::K_SHUT; // [RQ10]
      else if (halt_pend_ff) pick_kind = cbsc_pkg::K_HALT; // [RQ8]
      else if (irq_go)       pick_kind = cbsc_pkg::K_INTA1; // [RQ3]
      else if (!core_go)     pick_ok   = 1'b0;
   end

   // Bus state sequencing; hold is checked on the phase 1 start edge.
   always_comb begin
      nxt_state = state_ff;
      nxt_kind  = kind_ff;
      start     = 1'b0;
      unique case (state_ff)
         cbsc_pkg::S_IDLE: begin
            if (st_end && hold_s && !lock_ff) begin
               nxt_state = cbsc_pkg::S_HOLD; // [RQ20] [RQ1] [RQ21]
            end else if (st_end && pick_ok) begin
               nxt_state = cbsc_pkg::S_T1;
               nxt_kind  = pick_kind;
               start     = 1'b1;
            end
         end
         cbsc_pkg::S_T1: begin
            if (st_end) nxt_state = cbsc_pkg::S_T2;
         end
         cbsc_pkg::S_T2: begin
            if (cyc_end) begin
               if (kind_ff == cbsc_pkg::K_INTA1) nxt_state = cbsc_pkg::S_GAP;
               else                              nxt_state = cbsc_pkg::S_IDLE;
            end
         end
         cbsc_pkg::S_GAP: begin
            if (st_end && gap_cnt_ff == cbsc_pkg::IRQ_ACK_CYCLE_GAP_LAST) begin
               nxt_state = cbsc_pkg::S_T1; // [RQ5]
               nxt_kind  = cbsc_pkg::K_INTA2;
               start     = 1'b1;
            end
         end
         cbsc_pkg::S_HOLD: begin
            if (st_end && !hold_s) begin
               nxt_state = cbsc_pkg::S_IDLE; // [RQ21]
               if (pick_ok) begin
                  nxt_state = cbsc_pkg::S_T1;
                  nxt_kind  = pick_kind;
                  start     = 1'b1;
               end
            end
         end
         default: nxt_state = cbsc_pkg::S_IDLE;
      endcase
   end

   // State, kind and the idle-state counter between acknowledges.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         state_ff   <= cbsc_pkg::S_IDLE;
         kind_ff    <= cbsc_pkg::K_CORE;
         gap_cnt_ff <= 2'h0;
      end else begin
         state_ff <= nxt_state;
         kind_ff  <= nxt_kind;
         if (state_ff != cbsc_pkg::S_GAP) gap_cnt_ff <= 2'h0;
         else if (st_end)                 gap_cnt_ff <= gap_cnt_ff + 2'h1;
      end
   end

   // Lock rises with the edge that enters the first locked T1.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         lock_ff      <= 1'b0;
         lock_last_ff <= 1'b0;
         LOCK_N_O     <= 1'b1;
      end else if (start) begin
         if (nxt_kind == cbsc_pkg::K_INTA1 ||
             (nxt_kind == cbsc_pkg::K_CORE && CORE_LOCK_I)) begin
            lock_ff  <= 1'b1; // [RQ2] [RQ1]
            LOCK_N_O <= 1'b0;
         end
         lock_last_ff <= (nxt_kind == cbsc_pkg::K_CORE) && CORE_LOCK_LAST_I;
      end else if (cyc_end &&
                   (kind_ff == cbsc_pkg::K_INTA2 || lock_last_ff)) begin
         lock_ff  <= 1'b0; // [RQ2] [RQ5]
         LOCK_N_O <= 1'b1;
      end
   end

   // Pin drive; everything floats while the bus is surrendered.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         ADS_N_O               <= 1'b1;
         ADDR_O                <= 23'h000000;
         UPPER_BYTE_ENABLE_N_O <= 1'b1;
         LOWER_BYTE_ENABLE_N_O <= 1'b1;
         MIO_O                 <= 1'b0;
         DC_O                  <= 1'b0;
         WR_O                  <= 1'b0;
         DATA_O                <= 16'h0000;
         DATA_OE_O             <= 1'b0;
         BUS_OE_O              <= 1'b1;
         BUS_GRANT_ACK_O       <= 1'b0;
         cyc_rd_mem_ff         <= 1'b0;
      end else begin
         BUS_OE_O        <= (nxt_state != cbsc_pkg::S_HOLD); // [RQ19]
         BUS_GRANT_ACK_O <= (nxt_state == cbsc_pkg::S_HOLD); // [RQ19]
         if (start) begin
            ADS_N_O               <= 1'b0;
            UPPER_BYTE_ENABLE_N_O <= 1'b1; // [RQ4] [RQ8] [RQ10]
            LOWER_BYTE_ENABLE_N_O <= 1'b0;
            MIO_O                 <= 1'b1;
            DC_O                  <= 1'b0;
            WR_O                  <= 1'b1;
            DATA_OE_O             <= 1'b0; // [RQ7]
            cyc_rd_mem_ff         <= 1'b0;
            unique case (nxt_kind)
               cbsc_pkg::K_INTA1: begin
                  ADDR_O <= cbsc_pkg::INTA1_ADDR; // [RQ4]
                  MIO_O  <= 1'b0;
                  WR_O   <= 1'b0;
               end
               cbsc_pkg::K_INTA2: begin
                  ADDR_O <= cbsc_pkg::INTA2_ADDR; // [RQ4]
                  MIO_O  <= 1'b0;
                  WR_O   <= 1'b0;
               end
               cbsc_pkg::K_HALT: ADDR_O <= cbsc_pkg::HALT_ADDR; // [RQ8]
               cbsc_pkg::K_SHUT: ADDR_O <= cbsc_pkg::SHUT_ADDR; // [RQ10]
               default: begin
                  ADDR_O     <= CORE_ADDR_I;
                  ADDR_O[20] <= CORE_ADDR_I[20] && !a20_req_ff; // [RQ17]
                  UPPER_BYTE_ENABLE_N_O <= CORE_BHE_N_I;
                  LOWER_BYTE_ENABLE_N_O <= CORE_BLE_N_I;
                  MIO_O      <= CORE_MIO_I;
                  DC_O       <= CORE_DC_I;
                  WR_O       <= CORE_WR_I;
                  DATA_O     <= CORE_WDATA_I;
                  DATA_OE_O  <= CORE_WR_I;
                  cyc_rd_mem_ff <= CORE_MIO_I && !CORE_WR_I && !CORE_LOCK_I;
               end
            endcase
         end else begin
            if (st_end) ADS_N_O <= 1'b1;
            if (cyc_end) DATA_OE_O <= 1'b0;
         end
      end
   end

   // Cacheable input is taken at the phase 1 edge of T2.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) ken_smp_ff <= 1'b0;
      else if (state_ff == cbsc_pkg::S_T2 && !phase_ff)
         ken_smp_ff <= ken_s; // [RQ13]
   end
   assign low_region = (ADDR_O[23:16] == 8'h00) || (ADDR_O[23:16] == 8'h10);
   assign cacheable  = cyc_rd_mem_ff && !CORE_NONCACHE_I && // [RQ12]
                       ken_smp_ff && cfg_ff[cbsc_pkg::CFG_KEN_EN] &&
                       !(cfg_ff[cbsc_pkg::CFG_NC0] && low_region); // [RQ18]

   // Results of an ended cycle toward the core and the cache.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         CORE_DONE_O       <= 1'b0;
         CORE_RDATA_O      <= 16'h0000;
         CACHE_FILL_O      <= 1'b0;
         CACHE_FILL_DATA_O <= 16'h0000;
         IRQ_VEC_VALID_O   <= 1'b0;
         vector_ff         <= 8'h00;
      end else begin
         CORE_DONE_O     <= cyc_end && (kind_ff == cbsc_pkg::K_CORE);
         CACHE_FILL_O    <= cyc_end && cacheable &&
                            (kind_ff == cbsc_pkg::K_CORE); // [RQ13]
         IRQ_VEC_VALID_O <= cyc_end && (kind_ff == cbsc_pkg::K_INTA2);
         if (cyc_end && kind_ff == cbsc_pkg::K_CORE) begin
            CORE_RDATA_O      <= data_s;
            CACHE_FILL_DATA_O <= data_s; // [RQ13]
         end
         if (cyc_end && kind_ff == cbsc_pkg::K_INTA2)
            vector_ff <= data_s[7:0]; // [RQ6]
      end
   end
   assign IRQ_VECTOR_O = vector_ff;

   // Halt and shutdown; a new event wins over a clearing wake-up.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         halt_pend_ff <= 1'b0;
         shut_pend_ff <= 1'b0;
         halted_ff    <= 1'b0;
         shut_ff      <= 1'b0;
      end else begin
         if (CORE_HALT_I) halt_pend_ff <= 1'b1;
         else if (start && nxt_kind == cbsc_pkg::K_HALT) halt_pend_ff <= 1'b0;
         if (CORE_SHUTDOWN_I) shut_pend_ff <= 1'b1;
         else if (start && nxt_kind == cbsc_pkg::K_SHUT) shut_pend_ff <= 1'b0;
         if (cyc_end && kind_ff == cbsc_pkg::K_HALT)
            halted_ff <= 1'b1; // [RQ9]
         else if ((irq_s && CORE_IF_I) || nmi_pend_ff) halted_ff <= 1'b0;
         if (cyc_end && kind_ff == cbsc_pkg::K_SHUT) shut_ff <= 1'b1;
         else if (nmi_pend_ff) shut_ff <= 1'b0; // [RQ11]
      end
   end
   // Registered so the core never sees a glitch between the two flags.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) HALTED_O <= 1'b0;
      else        HALTED_O <= halted_ff || shut_ff; // [RQ9] [RQ11]
   end

   // Nmi edges are kept and offered to the core outside surrender.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         nmi_prev_ff <= 1'b0;
         nmi_pend_ff <= 1'b0;
         NMI_PEND_O  <= 1'b0;
      end else begin
         nmi_prev_ff <= nmi_s;
         if (nmi_s && !nmi_prev_ff) nmi_pend_ff <= 1'b1; // [RQ22]
         else if (CORE_NMI_ACK_I)   nmi_pend_ff <= 1'b0;
         NMI_PEND_O <= nmi_pend_ff && (state_ff != cbsc_pkg::S_HOLD) &&
                       !CORE_NMI_ACK_I; // [RQ22]
      end
   end

   // Flush and bit 20 mask are sampled at the phase 2 start edge.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         flush_prev_ff <= 1'b0;
         CACHE_INV_O   <= 1'b0;
         a20_req_ff    <= 1'b0;
         a20_cur_ff    <= 1'b0;
      end else begin
         flush_prev_ff <= flush_s;
         CACHE_INV_O   <= CORE_INVALIDATE_INSN_I || CORE_WRITEBACK_INVALIDATE_INSN_I || // [RQ14]
            (cfg_ff[cbsc_pkg::CFG_INVALIDATE_ON_GRANT_BIT] && state_ff != cbsc_pkg::S_HOLD &&
             nxt_state == cbsc_pkg::S_HOLD) ||
            (cfg_ff[cbsc_pkg::CFG_FLUSH_EN] && !phase_ff && flush_s &&
             flush_prev_ff); // [RQ15]
         if (!phase_ff)
            a20_req_ff <= cfg_ff[cbsc_pkg::CFG_A20_EN] && addr_bit20_mask_n_s &&
                          !CORE_PAGING_I; // [RQ16] [RQ17]
         if (start) a20_cur_ff <= a20_req_ff;
      end
   end
   assign A20_MASKED_O = a20_req_ff;

   // Register port: configuration is writable, the rest read only.
   always_ff @(posedge CLOCK_I or negedge rst_n) begin
      if (!rst_n) begin
         cfg_ff      <= cbsc_pkg::CFG_RST;
         REG_RDATA_O <= 32'h00000000;
      end else begin
         if (REG_WR_I && REG_ADDR_I == cbsc_pkg::REG_CONFIG)
            cfg_ff <= REG_WDATA_I[4:0];
         REG_RDATA_O <= 32'h00000000;
         if (REG_RD_I) begin
            unique case (REG_ADDR_I)
               cbsc_pkg::REG_CONFIG: REG_RDATA_O <= {27'h0000000, cfg_ff};
               cbsc_pkg::REG_STATUS: REG_RDATA_O <= {26'h0000000,
                  a20_req_ff, nmi_pend_ff, lock_ff,
                  state_ff == cbsc_pkg::S_HOLD, shut_ff, halted_ff};
               cbsc_pkg::REG_VECTOR: REG_RDATA_O <= {24'h000000, vector_ff};
               default: REG_RDATA_O <= 32'h00000000;
            endcase
         end
      end
   end

   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (!rst_n);

   property p_lock_no_grant;
      !LOCK_N_O |-> !BUS_GRANT_ACK_O;
   endproperty
   a_lock_no_grant: assert property (p_lock_no_grant) // [RQ1]
      else $error("Bus granted while lock is asserted.");

   property p_inta1_addr;
      !ADS_N_O && kind_ff == cbsc_pkg::K_INTA1 |->
         ADDR_O == 23'h000002 && UPPER_BYTE_ENABLE_N_O &&
         !LOWER_BYTE_ENABLE_N_O;
   endproperty
   a_inta1_addr: assert property (p_inta1_addr) // [RQ4]
      else $error("First acknowledge address wrong.");

   property p_irq_ack_cycle_gap;
      cyc_end && kind_ff == cbsc_pkg::K_INTA1 |=>
         (state_ff == cbsc_pkg::S_GAP && !LOCK_N_O)[*8] ##1
         (state_ff == cbsc_pkg::S_T1 && kind_ff == cbsc_pkg::K_INTA2);
   endproperty
   a_irq_ack_cycle_gap: assert property (p_irq_ack_cycle_gap) // [RQ5]
      else $error("Acknowledge gap is not four idle states under lock.");

   property p_irq_ack_cycle_float;
      (kind_ff == cbsc_pkg::K_INTA1 || kind_ff == cbsc_pkg::K_INTA2) &&
         (state_ff == cbsc_pkg::S_T1 || state_ff == cbsc_pkg::S_T2)
         |-> !DATA_OE_O;
   endproperty
   a_irq_ack_cycle_float: assert property (p_irq_ack_cycle_float) // [RQ7]
      else $error("Data driven during acknowledge.");

   property p_halt_def;
      !ADS_N_O && kind_ff == cbsc_pkg::K_HALT |-> MIO_O && !DC_O && WR_O &&
         LOCK_N_O && ADDR_O == 23'h000001 && UPPER_BYTE_ENABLE_N_O;
   endproperty
   a_halt_def: assert property (p_halt_def) // [RQ8]
      else $error("Halt indication cycle definition wrong.");

   property p_shut_stay;
      shut_ff && !nmi_pend_ff |=> shut_ff;
   endproperty
   a_shut_stay: assert property (p_shut_stay) // [RQ11]
      else $error("Shutdown left without nmi.");

   property p_hold_float;
      state_ff == cbsc_pkg::S_HOLD && $past(state_ff) == cbsc_pkg::S_HOLD
         |-> BUS_GRANT_ACK_O && !BUS_OE_O && !DATA_OE_O;
   endproperty
   a_hold_float: assert property (p_hold_float) // [RQ19]
      else $error("Bus not floated in surrender.");

   property p_a20_mask;
      !ADS_N_O && kind_ff == cbsc_pkg::K_CORE && a20_cur_ff |-> !ADDR_O[20];
   endproperty
   a_a20_mask: assert property (p_a20_mask) // [RQ17]
      else $error("Bit 20 not masked.");

   property p_vec_capture;
      cyc_end && kind_ff == cbsc_pkg::K_INTA2 |=>
         IRQ_VEC_VALID_O &&
         {8'h00, IRQ_VECTOR_O} == ($past(data_s) & 16'h00ff);
   endproperty
   a_vec_capture: assert property (p_vec_capture) // [RQ6]
      else $error("Vector not taken from low data byte.");
endmodule

// *** test/cbsc_sys_model.sv ***
// System-side model that answers bus cycles with ready and data.
module cbsc_sys_model (
   input  wire logic        clk_i,
   input  wire logic        ads_n_i,
   input  wire logic [7:0]  vec_i,
   output      logic        ready_n_o,
   output      logic [15:0] data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   initial ready_n_o = 1'b1;
   initial data_o = 16'h0000;
   // Ready stays low four clocks so one state end always catches it.
   always @(posedge clk_i) begin
      cnt <= !ads_n_i ? 6 : (cnt > 0 ? cnt - 1 : 0);
      ready_n_o <= !(cnt > 0 && cnt < 5);
      // Released lines toggle so that stale data never looks valid.
      data_o <= cnt > 0 ? {~vec_i, vec_i} : ~data_o;
   end
endmodule

// *** test/cbsc_bus_special_bench.sv ***
// Self-checking bench for the special-cycle block.
module cbsc_bus_special_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic CLOCK_I=0, RSTN_I=0, REG_WR_I=0, REG_RD_I=0, CORE_REQ_I=0;
   logic CORE_WR_I=0, CORE_MIO_I=0, CORE_DC_I=0, CORE_LOCK_I=0, HOLD_I=0;
   logic CORE_BHE_N_I=0, CORE_BLE_N_I=0, CORE_LOCK_LAST_I=0, NMI_I=0;
   logic CORE_NONCACHE_I=0, CORE_IF_I=0, CORE_PAGING_I=0, CORE_HALT_I=0;
   logic CORE_SHUTDOWN_I=0, CORE_INVALIDATE_INSN_I=0, CORE_WRITEBACK_INVALIDATE_INSN_I=0;
   logic CORE_NMI_ACK_I=0, MASKABLE_IRQ_REQ_I=0, CACHEABLE_CYCLE_N_I=1;
   logic FLUSH_N_I=1, ADDR_BIT20_MASK_N_I=1, READY_N_I, ADS_N_O, MIO_O;
   logic DC_O, WR_O, CORE_DONE_O, NMI_PEND_O, HALTED_O, IRQ_VEC_VALID_O;
   logic CACHE_FILL_O, CACHE_INV_O, A20_MASKED_O, UPPER_BYTE_ENABLE_N_O;
   logic LOCK_N_O, LOWER_BYTE_ENABLE_N_O, BUS_OE_O, DATA_OE_O;
   logic BUS_GRANT_ACK_O;
   logic [7:0]  REG_ADDR_I=0, IRQ_VECTOR_O, vec=0;
   logic [31:0] REG_WDATA_I=0, REG_RDATA_O, r;
   logic [23:1] CORE_ADDR_I=0, ADDR_O;
   logic [15:0] CORE_WDATA_I=0, DATA_I, CORE_RDATA_O, CACHE_FILL_DATA_O;
   logic [15:0] DATA_O;
   int          error_cnt = 0;
   int          tests_run = 0;
   cbsc_bus_special DUT (.*);
   cbsc_sys_model sys (.clk_i(CLOCK_I), .ads_n_i(ADS_N_O), .vec_i(vec),
      .ready_n_o(READY_N_I), .data_o(DATA_I));
   // Free-running 100 MHz clock.
   always #5 CLOCK_I = ~CLOCK_I;
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task automatic end_sim();
      $display("Compares %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   // Bounded wait, sampled just after each edge once updates settle.
   task automatic wt(ref logic s, input logic v);
      for (int i = 0; i < 300 && s !== v; i++) @(posedge CLOCK_I) #1;
      if (s !== v) begin
         error_cnt++;
         end_sim();
      end
   endtask
   // One register access; for a read, d is the expected value.
   task automatic reg_op(input logic w, input logic [7:0] a,
                         input logic [31:0] d);
      @(posedge CLOCK_I);
      REG_ADDR_I  <= a;
      REG_WDATA_I <= d;
      REG_WR_I    <= w;
      REG_RD_I    <= !w;
      @(posedge CLOCK_I);
      REG_WR_I    <= 0;
      REG_RD_I    <= 0;
      #1;
      if (!w) chk(REG_RDATA_O, d);
   endtask
   // Registers, acknowledge pair, halt with wake, then hold handover.
   initial begin
      r = $urandom(26886);
      vec = 8'($urandom);
      repeat (6) @(posedge CLOCK_I);
      RSTN_I <= 1;
      repeat (6) @(posedge CLOCK_I);
      reg_op(0, cbsc_pkg::REG_CONFIG, 32'h0);
      r = $urandom % 32;
      reg_op(1, cbsc_pkg::REG_CONFIG, r);
      reg_op(0, cbsc_pkg::REG_CONFIG, r);
      reg_op(0, 8'hfc, 32'h0);
      @(posedge CLOCK_I);
      CORE_IF_I <= 1;
      MASKABLE_IRQ_REQ_I <= 1;
      wt(ADS_N_O, 0);
      chk({ADDR_O, UPPER_BYTE_ENABLE_N_O, LOCK_N_O}, {23'h2, 2'b10});
      chk(LOWER_BYTE_ENABLE_N_O, 1'b0);
      @(posedge CLOCK_I);
      MASKABLE_IRQ_REQ_I <= 0;
      wt(ADS_N_O, 1);
      wt(ADS_N_O, 0);
      chk({ADDR_O, UPPER_BYTE_ENABLE_N_O, LOCK_N_O}, {23'h0, 2'b10});
      wt(IRQ_VEC_VALID_O, 1);
      chk(IRQ_VECTOR_O, vec);
      reg_op(0, cbsc_pkg::REG_VECTOR, {24'h0, vec});
      @(posedge CLOCK_I);
      CORE_HALT_I <= 1;
      @(posedge CLOCK_I);
      CORE_HALT_I <= 0;
      wt(ADS_N_O, 0);
      chk({ADDR_O, MIO_O, DC_O, WR_O, LOCK_N_O}, {23'h1, 4'b1011});
      wt(HALTED_O, 1);
      @(posedge CLOCK_I);
      NMI_I <= 1;
      wt(HALTED_O, 0);
      chk(NMI_PEND_O, 1'b1);
      @(posedge CLOCK_I);
      HOLD_I <= 1;
      wt(BUS_GRANT_ACK_O, 1);
      chk({BUS_OE_O, DATA_OE_O}, 2'b00);
      @(posedge CLOCK_I);
      HOLD_I <= 0;
      wt(BUS_GRANT_ACK_O, 0);
      chk(BUS_OE_O, 1'b1);
      // Clear the old nmi, then a masked, cacheable core read.
      @(posedge CLOCK_I);
      CORE_NMI_ACK_I <= 1;
      ADDR_BIT20_MASK_N_I <= 0;
      CACHEABLE_CYCLE_N_I <= 0;
      @(posedge CLOCK_I);
      CORE_NMI_ACK_I <= 0;
      reg_op(1, cbsc_pkg::REG_CONFIG, 32'h9);
      repeat (4) @(posedge CLOCK_I);
      CORE_ADDR_I <= 23'h080000;
      CORE_MIO_I <= 1;
      CORE_REQ_I <= 1;
      wt(ADS_N_O, 0);
      chk({ADDR_O[20], A20_MASKED_O}, 2'b01);
      wt(CORE_DONE_O, 1);
      chk({CACHE_FILL_O, CACHE_FILL_DATA_O}, {1'b1, ~vec, vec});
      chk(CORE_RDATA_O, {~vec, vec});
      @(posedge CLOCK_I);
      CORE_REQ_I <= 0;
      CORE_INVALIDATE_INSN_I <= 1;
      @(posedge CLOCK_I);
      CORE_INVALIDATE_INSN_I <= 0;
      #1 chk(CACHE_INV_O, 1'b1);
      // Shutdown must ignore the maskable request and wake on nmi.
      @(posedge CLOCK_I);
      CORE_SHUTDOWN_I <= 1;
      @(posedge CLOCK_I);
      CORE_SHUTDOWN_I <= 0;
      wt(ADS_N_O, 0);
      chk({ADDR_O, MIO_O, DC_O, WR_O, LOCK_N_O}, {23'h0, 4'b1011});
      wt(HALTED_O, 1);
      @(posedge CLOCK_I);
      MASKABLE_IRQ_REQ_I <= 1;
      NMI_I <= 0;
      repeat (30) @(posedge CLOCK_I);
      #1 chk({HALTED_O, ADS_N_O}, 2'b11);
      @(posedge CLOCK_I);
      NMI_I <= 1;
      wt(HALTED_O, 0);
      end_sim();
   end
endmodule
